// >>> brake_sequence_controller.sv
// Function
// - Mode selector value 0 normal, 7 sequence with feedback, 8 sequence without.
// - Speed and current thresholds met, then release request after detection delay.
// - With feedback, hold until start wait elapses after release complete, then accelerate.
// - Without feedback, hold until start wait elapses after the request, then accelerate.
// - Drop the release request once decelerating speed reaches the engage frequency.
// - With feedback, output off after stop wait from release complete going inactive.
// - Without feedback, output off after stop wait from release request dropping.
// - Frequencies accepted within 0 to 30 Hz, release not above engage.
// - Release current 0 to 200 percent of rated, default 130 percent.
// - Current detection delay 0 to 2 s, default 0.3 s.
// - Start and stop wait times 0 to 5 s, default 0.3 s each.
// - Sequence works only in external, combined 1 or network operation.
// - Release complete on input code 15; request on output code 20 or 120.
// - Any supervision fault trips: output off and release request dropped.
// - No release request more than 2 s after start gives a fault.
// - No release complete more than 2 s after the request gives a fault.
// - Release complete still on 2 s after request dropped at stop gives a fault.
// - Jog or second function at standstill suspends the sequence and wins.
// - Jog and second function are ignored while the sequence runs.
// - Automatic restart after power loss is off when a sequence mode is chosen.
`timescale 1ns/10ps
module brake_sequence_controller
  import brake_seq_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic CLK,                // System clock, 10 MHz.
  input wire logic RST_N,              // Synchronous reset, active low.
  input wire logic [7:0] ADDR,         // Register word address.
  input wire logic [15:0] WR_DATA,     // Register write data.
  input wire logic WR_STB,             // Write strobe.
  input wire logic RD_STB,             // Read strobe.
  output logic [15:0] RD_DATA,         // Read data, one cycle after the strobe.
  input wire logic START_FWD,          // Forward start command.
  input wire logic START_REV,          // Reverse start command.
  input wire logic [15:0] SPEED_CMD,   // Internal speed command in 0.01 Hz.
  input wire logic [15:0] OUT_CURRENT, // Output current in percent of rated.
  input wire logic [2:0] OPER_MODE,    // Present operation mode of the drive.
  input wire logic JOG_IN,             // Jog request from its terminal.
  input wire logic SECOND_FUNC_IN,     // Second function select from its terminal.
  input wire logic RELEASE_COMPLETE,   // Brake release complete contact.
  input wire logic DRIVE_RESET,        // Drive reset, clears a latched fault.
  output logic RELEASE_OUT,            // Release request terminal, polarity by code.
  output logic OUTPUT_ON,              // Drive output stage enabled.
  output logic HOLD_FREQ,              // Hold the present output frequency.
  output logic ACCEL_EN,               // Ramp to the set speed allowed.
  output logic JOG_OUT,                // Jog request passed to the drive.
  output logic SECOND_FUNC_OUT,        // Second function passed to the drive.
  output logic AUTO_RESTART_EN,        // Automatic restart after power loss allowed.
  output logic FAULT,                  // Brake supervision trip.
  output logic [3:0] FAULT_CODE        // Sticky fault cause bits.
);

  params_t par_q;
  params_t par_d;
  logic [15:0] control_q;
  logic reject_q;
  logic reject_d;
  seq_state_t state_q;
  seq_state_t state_d;
  seq_state_t seq_next;
  logic bypass_q;
  logic bypass_d;
  logic done_q;
  logic req_q;
  logic req_d;
  logic [3:0] fault_set;
  logic [3:0] fault_code_d;
  logic tick;
  logic [15:0] seq_cnt;
  logic [15:0] sup_cnt;
  logic [15:0] rd_mux;
  logic [15:0] status_word;

  // Write decode per register.
  wire wr_rel_freq = WR_STB && ADDR == ADDR_RELEASE_FREQ;
  wire wr_rel_cur = WR_STB && ADDR == ADDR_RELEASE_CURRENT;
  wire wr_detect = WR_STB && ADDR == ADDR_DETECT_DELAY;
  wire wr_start_wait = WR_STB && ADDR == ADDR_START_WAIT;
  wire wr_eng_freq = WR_STB && ADDR == ADDR_ENGAGE_FREQ;
  wire wr_stop_wait = WR_STB && ADDR == ADDR_STOP_WAIT;
  wire wr_mode = WR_STB && ADDR == ADDR_ACCEL_MODE;
  wire wr_control = WR_STB && ADDR == ADDR_CONTROL;

  wire ok_rel_freq = WR_DATA <= FREQ_MAX && WR_DATA <= par_q.engage_frequency;
  wire ok_eng_freq = WR_DATA <= FREQ_MAX && WR_DATA >= par_q.release_frequency;
  wire ok_rel_cur = WR_DATA <= CURRENT_MAX;
  wire ok_detect = WR_DATA <= DETECT_MAX;
  wire ok_wait = WR_DATA <= WAIT_MAX;
  wire ok_mode = WR_DATA == MODE_NORMAL || WR_DATA == MODE_SHORTEST ||
                 WR_DATA == MODE_SHORTEST_ALT || WR_DATA == MODE_BRAKE_FB ||
                 WR_DATA == MODE_BRAKE_TIMED;

  // A write that fails its check leaves the setting unchanged.
  wire acc_rel_freq = wr_rel_freq && ok_rel_freq;
  wire acc_rel_cur = wr_rel_cur && ok_rel_cur;
  wire acc_detect = wr_detect && ok_detect;
  wire acc_start_wait = wr_start_wait && ok_wait;
  wire acc_eng_freq = wr_eng_freq && ok_eng_freq;
  wire acc_stop_wait = wr_stop_wait && ok_wait;
  wire acc_mode = wr_mode && ok_mode;
  wire wr_checked = wr_rel_freq || wr_rel_cur || wr_detect || wr_start_wait ||
                    wr_eng_freq || wr_stop_wait || wr_mode;
  wire wr_ok = acc_rel_freq || acc_rel_cur || acc_detect || acc_start_wait ||
               acc_eng_freq || acc_stop_wait || acc_mode;

  // Next values of the settings.
  assign par_d = '{
    release_frequency: acc_rel_freq ? WR_DATA : par_q.release_frequency,
    release_current: acc_rel_cur ? WR_DATA : par_q.release_current,
    current_detect_delay: acc_detect ? WR_DATA : par_q.current_detect_delay,
    start_wait_time: acc_start_wait ? WR_DATA : par_q.start_wait_time,
    engage_frequency: acc_eng_freq ? WR_DATA : par_q.engage_frequency,
    stop_wait_time: acc_stop_wait ? WR_DATA : par_q.stop_wait_time,
    accel_mode_select: acc_mode ? WR_DATA : par_q.accel_mode_select
  };
  assign reject_d = wr_checked ? !wr_ok : reject_q;

  wire mode_fb = par_q.accel_mode_select == MODE_BRAKE_FB;
  wire mode_timed = par_q.accel_mode_select == MODE_BRAKE_TIMED;
  wire mode_sel = mode_fb || mode_timed;

  wire opm_ok = OPER_MODE == OPM_EXTERNAL || OPER_MODE == OPM_COMBINED1 ||
                OPER_MODE == OPM_NETWORK;

  wire in_assigned = control_q[CTRL_IN_LSB +: 8] == IN_CODE_RELEASE_DONE;
  wire out_neg = control_q[CTRL_OUT_LSB +: 8] == OUT_CODE_NEG;
  wire out_assigned = out_neg || control_q[CTRL_OUT_LSB +: 8] == OUT_CODE_POS;
  wire done = RELEASE_COMPLETE && in_assigned;

  // Start, release condition and sequence enable.
  wire start_cmd = START_FWD || START_REV;
  wire rel_cond = SPEED_CMD >= par_q.release_frequency &&
                  OUT_CURRENT >= par_q.release_current;
  wire seq_en = mode_sel && opm_ok && !bypass_q;
  wire seq_en_d = mode_sel && opm_ok && !bypass_d;

  // jog or second function at standstill suspends the sequence
  assign bypass_d = (state_q == ST_IDLE) ?
                    ((JOG_IN || SECOND_FUNC_IN) || (bypass_q && start_cmd)) : bypass_q;

  // The delay timer restarts on every state change, and in detection whenever
  // the thresholds are lost, so the detection delay counts only a steady condition.
  wire seq_clr = (state_d != state_q) || (state_q == ST_DETECT && !rel_cond);
  wire sup_clr = state_d != state_q;

  tick_divider #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(CLK),
    .rst_n(RST_N),
    .tick_q(tick)
  );

  tick_timer u_seq_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(tick),
    .clr(seq_clr),
    .cnt_q(seq_cnt)
  );

  tick_timer u_sup_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(tick),
    .clr(sup_clr),
    .cnt_q(sup_cnt)
  );

  assign fault_set[FLT_NO_REQ] = state_q == ST_DETECT && sup_cnt > FAULT_TICKS;
  assign fault_set[FLT_NO_FB] = state_q == ST_FB_WAIT && sup_cnt > FAULT_TICKS;
  assign fault_set[FLT_FB_LOST] = mode_fb && done_q && !done &&
    (state_q == ST_START_WAIT || state_q == ST_RUN || state_q == ST_DECEL);
  assign fault_set[FLT_NO_ENGAGE] = state_q == ST_ENGAGE_WAIT && sup_cnt > FAULT_TICKS;

  // set wins over the reset clear
  assign fault_code_d = (FAULT_CODE & ~{4{DRIVE_RESET}}) | fault_set;

  // Sequencer next state before fault override.
  always_comb
  begin
    seq_next = state_q;
    case (state_q)
      ST_IDLE:
        if (seq_en && start_cmd)
          seq_next = ST_DETECT;
      ST_DETECT:
        if (!start_cmd)
          seq_next = ST_IDLE;
        else if (rel_cond && seq_cnt >= par_q.current_detect_delay)
          seq_next = mode_fb ? ST_FB_WAIT : ST_START_WAIT;
      ST_FB_WAIT:
        if (!start_cmd)
          seq_next = ST_DECEL;
        else if (done)
          seq_next = ST_START_WAIT;
      ST_START_WAIT:
        if (!start_cmd)
          seq_next = ST_DECEL;
        else if (seq_cnt >= par_q.start_wait_time)
          seq_next = ST_RUN;
      ST_RUN:
        if (!start_cmd)
          seq_next = ST_DECEL;
      ST_DECEL:
        if (SPEED_CMD <= par_q.engage_frequency)
          seq_next = mode_fb ? ST_ENGAGE_WAIT : ST_STOP_WAIT;
      // wait for release complete to clear
      ST_ENGAGE_WAIT:
        if (!done)
          seq_next = ST_STOP_WAIT;
      ST_STOP_WAIT:
        if (seq_cnt >= par_q.stop_wait_time)
          seq_next = ST_IDLE;
      // leave a trip only on drive reset
      ST_FAULT:
        if (DRIVE_RESET)
          seq_next = ST_IDLE;
      default:
        seq_next = ST_IDLE;
    endcase
  end

  // any fault forces the trip state
  assign state_d = (|fault_set) ? ST_FAULT : seq_next;

  // Outputs follow the next state so that they line up with the state register.
  wire in_seq_d = state_d != ST_IDLE && state_d != ST_FAULT;
  assign req_d = state_d == ST_FB_WAIT || state_d == ST_START_WAIT ||
                 state_d == ST_RUN || state_d == ST_DECEL;
  // output stage off in a trip
  wire out_on_d = (state_d == ST_IDLE) ? (start_cmd && !seq_en_d) : (state_d != ST_FAULT);
  wire hold_d = state_d == ST_FB_WAIT || state_d == ST_START_WAIT;
  wire accel_d = state_d == ST_RUN || (state_d == ST_IDLE && start_cmd && !seq_en_d);
  wire rel_out_d = out_assigned && (out_neg ? !req_d : req_d);
  // jog and second function blocked while sequencing
  wire jog_d = JOG_IN && !in_seq_d;
  wire second_d = SECOND_FUNC_IN && !in_seq_d;
  wire restart_d = !mode_sel;

  // Register read selection, unmapped words read as zero.
  assign status_word = {4'h0, bypass_q, reject_q, done, req_q, FAULT_CODE, state_q};
  assign rd_mux = (ADDR == ADDR_RELEASE_FREQ) ? par_q.release_frequency :
                  (ADDR == ADDR_RELEASE_CURRENT) ? par_q.release_current :
                  (ADDR == ADDR_DETECT_DELAY) ? par_q.current_detect_delay :
                  (ADDR == ADDR_START_WAIT) ? par_q.start_wait_time :
                  (ADDR == ADDR_ENGAGE_FREQ) ? par_q.engage_frequency :
                  (ADDR == ADDR_STOP_WAIT) ? par_q.stop_wait_time :
                  (ADDR == ADDR_ACCEL_MODE) ? par_q.accel_mode_select :
                  (ADDR == ADDR_CONTROL) ? control_q :
                  (ADDR == ADDR_STATUS) ? status_word : 16'h0000;

  // Settings, control word and read data.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      par_q <= '{RST_RELEASE_FREQ, RST_RELEASE_CURRENT, RST_DETECT_DELAY,
                 RST_START_WAIT, RST_ENGAGE_FREQ, RST_STOP_WAIT, RST_ACCEL_MODE};
      control_q <= RST_CONTROL;
      reject_q <= 1'b0;
      RD_DATA <= 16'h0000;
    end
    else
    begin
      par_q <= par_d;
      control_q <= wr_control ? WR_DATA : control_q;
      reject_q <= reject_d;
      RD_DATA <= RD_STB ? rd_mux : 16'h0000;
    end
  end

  // Sequencer state and suspension flag.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_q <= ST_IDLE;
      bypass_q <= 1'b0;
      done_q <= 1'b0;
      req_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      bypass_q <= bypass_d;
      done_q <= done;
      req_q <= req_d;
    end
  end

  // Registered drive and terminal outputs.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      RELEASE_OUT <= 1'b0;
      OUTPUT_ON <= 1'b0;
      HOLD_FREQ <= 1'b0;
      ACCEL_EN <= 1'b0;
      JOG_OUT <= 1'b0;
      SECOND_FUNC_OUT <= 1'b0;
      AUTO_RESTART_EN <= 1'b1;
      FAULT <= 1'b0;
      FAULT_CODE <= 4'h0;
    end
    else
    begin
      RELEASE_OUT <= rel_out_d;
      OUTPUT_ON <= out_on_d;
      HOLD_FREQ <= hold_d;
      ACCEL_EN <= accel_d;
      JOG_OUT <= jog_d;
      SECOND_FUNC_OUT <= second_d;
      AUTO_RESTART_EN <= restart_d;
      FAULT <= state_d == ST_FAULT;
      FAULT_CODE <= fault_code_d;
    end
  end

  chk_trip_outputs_off: assert property (
    @(posedge CLK) disable iff (!RST_N)
    state_q == ST_FAULT |-> !req_q && !OUTPUT_ON && FAULT)
    else $error("Trip state with output or release request still on.");

  chk_fault_stays_latched: assert property (
    @(posedge CLK) disable iff (!RST_N)
    state_q == ST_FAULT && !DRIVE_RESET |=> state_q == ST_FAULT)
    else $error("Fault left without a drive reset.");

  chk_no_request_trip: assert property (
    @(posedge CLK) disable iff (!RST_N)
    state_q == ST_DETECT && sup_cnt > FAULT_TICKS |=> FAULT && FAULT_CODE[FLT_NO_REQ])
    else $error("Missing release request did not trip.");

  chk_no_feedback_trip: assert property (
    @(posedge CLK) disable iff (!RST_N)
    state_q == ST_FB_WAIT && sup_cnt > FAULT_TICKS |=> FAULT && FAULT_CODE[FLT_NO_FB])
    else $error("Missing release complete did not trip.");

  chk_feedback_lost_trip: assert property (
    @(posedge CLK) disable iff (!RST_N)
    mode_fb && state_q == ST_RUN && $fell(done) |=> state_q == ST_FAULT && !req_q)
    else $error("Lost release complete did not trip.");

  chk_engage_stuck_trip: assert property (
    @(posedge CLK) disable iff (!RST_N)
    state_q == ST_ENGAGE_WAIT && done && sup_cnt > FAULT_TICKS
    |=> FAULT_CODE[FLT_NO_ENGAGE] && !OUTPUT_ON)
    else $error("Stuck release complete at stop did not trip.");

  chk_request_drops_engage: assert property (
    @(posedge CLK) disable iff (!RST_N)
    state_q == ST_DECEL && SPEED_CMD <= par_q.engage_frequency && fault_set == 4'h0
    |=> !req_q ##1 OUTPUT_ON || state_q == ST_IDLE || state_q == ST_FAULT)
    else $error("Release request not dropped at engage frequency.");

  chk_timed_start_wait: assert property (
    @(posedge CLK) disable iff (!RST_N)
    mode_timed && state_q == ST_START_WAIT && start_cmd && fault_set == 4'h0 &&
    seq_cnt >= par_q.start_wait_time |=> ACCEL_EN && !HOLD_FREQ && req_q)
    else $error("Accel not released after start wait without feedback.");

  chk_restart_blocked: assert property (
    @(posedge CLK) disable iff (!RST_N)
    mode_sel && $stable(par_q.accel_mode_select) |=> !AUTO_RESTART_EN)
    else $error("Automatic restart allowed in sequence mode.");

  chk_jog_ignored_run: assert property (
    @(posedge CLK) disable iff (!RST_N)
    state_q == ST_RUN |-> !JOG_OUT && !SECOND_FUNC_OUT)
    else $error("Jog or second function passed while sequencing.");

endmodule

// >>> brake_seq_pkg.sv
package brake_seq_pkg;

  // Clock and timer tick, times are counted in ticks of one time unit.
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 10_000_000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TIME_UNIT_MS = 10;
  localparam int FAULT_TIME_MS = 2000;
  localparam logic [15:0] FAULT_TICKS = 16'(FAULT_TIME_MS / TIME_UNIT_MS);

  // Register word offsets on the parameter port.
  localparam logic [7:0] ADDR_RELEASE_FREQ = 8'h00;
  localparam logic [7:0] ADDR_RELEASE_CURRENT = 8'h01;
  localparam logic [7:0] ADDR_DETECT_DELAY = 8'h02;
  localparam logic [7:0] ADDR_START_WAIT = 8'h03;
  localparam logic [7:0] ADDR_ENGAGE_FREQ = 8'h04;
  localparam logic [7:0] ADDR_STOP_WAIT = 8'h05;
  localparam logic [7:0] ADDR_ACCEL_MODE = 8'h06;
  localparam logic [7:0] ADDR_CONTROL = 8'h07;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Upper limits of the settings, frequency in 0.01 Hz, current in percent, time in units.
  localparam logic [15:0] FREQ_MAX = 16'h0BB8;
  localparam logic [15:0] CURRENT_MAX = 16'h00C8;
  localparam logic [15:0] DETECT_MAX = 16'h00C8;
  localparam logic [15:0] WAIT_MAX = 16'h01F4;

  // Values after reset.
  localparam logic [15:0] RST_RELEASE_FREQ = 16'h012C;
  localparam logic [15:0] RST_RELEASE_CURRENT = 16'h0082;
  localparam logic [15:0] RST_DETECT_DELAY = 16'h001E;
  localparam logic [15:0] RST_START_WAIT = 16'h001E;
  localparam logic [15:0] RST_ENGAGE_FREQ = 16'h02BC;
  localparam logic [15:0] RST_STOP_WAIT = 16'h001E;
  localparam logic [15:0] RST_ACCEL_MODE = 16'h0000;
  localparam logic [15:0] RST_CONTROL = 16'h0F14;

  // Acceleration mode selector codes.
  localparam logic [15:0] MODE_NORMAL = 16'h0000;
  localparam logic [15:0] MODE_SHORTEST = 16'h0001;
  localparam logic [15:0] MODE_SHORTEST_ALT = 16'h000B;
  localparam logic [15:0] MODE_BRAKE_FB = 16'h0007;
  localparam logic [15:0] MODE_BRAKE_TIMED = 16'h0008;

  // Terminal function codes held in the control register.
  localparam int CTRL_IN_LSB = 8;
  localparam int CTRL_OUT_LSB = 0;
  localparam logic [7:0] IN_CODE_RELEASE_DONE = 8'h0F;
  localparam logic [7:0] OUT_CODE_POS = 8'h14;
  localparam logic [7:0] OUT_CODE_NEG = 8'h78;

  // Operation mode codes reported by the drive.
  localparam logic [2:0] OPM_EXTERNAL = 3'h0;
  localparam logic [2:0] OPM_PANEL = 3'h1;
  localparam logic [2:0] OPM_COMBINED1 = 3'h2;
  localparam logic [2:0] OPM_COMBINED2 = 3'h3;
  localparam logic [2:0] OPM_NETWORK = 3'h4;

  // Fault bit positions and status register fields.
  localparam int FLT_NO_REQ = 0;
  localparam int FLT_NO_FB = 1;
  localparam int FLT_FB_LOST = 2;
  localparam int FLT_NO_ENGAGE = 3;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_FAULT_LSB = 4;
  localparam int STAT_REQ_BIT = 8;
  localparam int STAT_DONE_BIT = 9;
  localparam int STAT_REJECT_BIT = 10;
  localparam int STAT_BYPASS_BIT = 11;

  // Sequencer states, Gray coded along the feedback-mode start and stop path.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DETECT = 4'h1,
    ST_FB_WAIT = 4'h3,
    ST_START_WAIT = 4'h2,
    ST_RUN = 4'h6,
    ST_DECEL = 4'h7,
    ST_ENGAGE_WAIT = 4'h5,
    ST_STOP_WAIT = 4'h4,
    ST_FAULT = 4'hC
  } seq_state_t;

  // Programmable settings of the brake sequence.
  typedef struct packed {
    logic [15:0] release_frequency;
    logic [15:0] release_current;
    logic [15:0] current_detect_delay;
    logic [15:0] start_wait_time;
    logic [15:0] engage_frequency;
    logic [15:0] stop_wait_time;
    logic [15:0] accel_mode_select;
  } params_t;

endpackage

// >>> tick_divider.sv
`timescale 1ns/10ps
module tick_divider
  import brake_seq_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic clk,    // System clock.
  input wire logic rst_n,  // Synchronous reset, active low.
  output logic tick_q      // One-cycle pulse every CYCLES clocks.
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic wrap;

  // The counter wraps after CYCLES clocks and marks the wrap with a pulse.
  assign wrap = (cnt_q == 32'(CYCLES - 1));
  assign cnt_d = wrap ? 32'h00000000 : cnt_q + 32'h00000001;

  // Count register and tick flag.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= wrap;
    end
  end

endmodule

// >>> tick_timer.sv
`timescale 1ns/10ps
module tick_timer
  import brake_seq_pkg::*;
(
  input wire logic clk,       // System clock.
  input wire logic rst_n,     // Synchronous reset, active low.
  input wire logic tick,      // Time unit pulse.
  input wire logic clr,       // Restart the count from zero.
  output logic [15:0] cnt_q   // Elapsed time units, saturating.
);

  logic [15:0] cnt_d;

  // Clear wins over counting; the count stops at full scale instead of wrapping.
  assign cnt_d = clr ? 16'h0000 :
                 (tick && cnt_q != 16'hFFFF) ? cnt_q + 16'h0001 : cnt_q;

  // Elapsed time register.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end

endmodule

// >>> brake_actuator.sv
`timescale 1ns/10ps
module brake_actuator
(
  input wire logic clk,    // System clock.
  input wire logic rst_n,  // Synchronous reset, active low.
  input wire logic req,    // Release request, active high.
  input wire logic stuck,  // Contact frozen in its present position while high.
  input wire logic drop,   // Contact forced open while high.
  output logic done_q      // Release complete contact.
);
  logic [7:0] cnt_q;

  // The contact follows the request after 32 cycles of mechanical travel.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= 8'h00;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q <= (req == done_q || stuck) ? 8'h00 : cnt_q + 8'h01;
      if (drop)
        done_q <= 1'b0;
      else if (cnt_q == 8'h1F && !stuck)
        done_q <= req;
    end
  end
endmodule

// >>> tb_brake_sequence_controller.sv
`timescale 1ns/10ps
module tb_brake_sequence_controller;
  import brake_seq_pkg::*;
  localparam int TICKS = 10;
  localparam int ACCEL_CYC = 100 * TICKS;
  logic clk, rst_n, wr_stb, rd_stb, start, rev, jog, drv_rst, stuck, drop, rel_done;
  logic rel_out, out_on, hold, accel, jog_o, sec_o, restart, fault;
  logic [7:0] addr;
  logic [15:0] wr_data, rd_data, speed, cur, d;
  logic [2:0] opm;
  logic [3:0] fcode, mon;
  logic [15:0] rst_tab [8] = '{RST_RELEASE_FREQ, RST_RELEASE_CURRENT, RST_DETECT_DELAY,
    RST_START_WAIT, RST_ENGAGE_FREQ, RST_STOP_WAIT, RST_ACCEL_MODE, RST_CONTROL};
  int fails = 0;
  int tests_run = 0;
  int seed = 20423;
  int n;
  assign mon = {fault, out_on, accel, rel_out};

  brake_sequence_controller #(.TICK_CYCLES(TICKS)) i_dut (.CLK(clk), .RST_N(rst_n),
    .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
    .START_FWD(start), .START_REV(rev), .SPEED_CMD(speed), .OUT_CURRENT(cur),
    .OPER_MODE(opm), .JOG_IN(jog), .SECOND_FUNC_IN(jog), .RELEASE_COMPLETE(rel_done),
    .DRIVE_RESET(drv_rst), .RELEASE_OUT(rel_out), .OUTPUT_ON(out_on), .HOLD_FREQ(hold),
    .ACCEL_EN(accel), .JOG_OUT(jog_o), .SECOND_FUNC_OUT(sec_o), .AUTO_RESTART_EN(restart),
    .FAULT(fault), .FAULT_CODE(fcode));
  brake_actuator i_brake (.clk(clk), .rst_n(rst_n), .req(rel_out), .stuck(stuck),
    .drop(drop), .done_q(rel_done));

  // Free running clock of 100 ns.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic int cyc_of(logic [15:0] t);
    return int'(t) * TICKS - TICKS;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Outputs are sampled 1 ns after the edge so that its updates have landed.
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    wr_stb <= 1'b1;
    addr <= a;
    wr_data <= v;
    cyc(1);
    wr_stb <= 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    rd_stb <= 1'b1;
    addr <= a;
    cyc(1);
    rd_stb <= 1'b0;
    v = rd_data;
    cyc(1);
  endtask

  task automatic wait_for(input string name, input int idx, input logic val, input int lim);
    n = 0;
    while (mon[idx] !== val && n < lim)
    begin
      cyc(1);
      n++;
    end
    check(name, 16'(val), 16'(mon[idx]));
    if (mon[idx] !== val)
      test_done();
  endtask

  // One start and stop with random speed and current at or above the thresholds.
  task automatic run_seq(input logic [15:0] mode);
    wr(ADDR_ACCEL_MODE, mode);
    cyc(2);
    check("restart", 16'h0, 16'(restart));
    speed <= 16'h0300 + 16'($unsigned($random(seed)) % 2048);
    cur <= 16'h0082 + 16'($unsigned($random(seed)) % 70);
    start <= 1'b1;
    wait_for("request on", 0, 1'b1, 400);
    check("detect time", 16'h1, 16'(n >= cyc_of(RST_DETECT_DELAY)));
    check("hold on", 16'h1, 16'(hold));
    wait_for("accel on", 1, 1'b1, 800);
    check("start wait", 16'h1, 16'(n >= cyc_of(RST_START_WAIT)));
    check("hold off", 16'h0, 16'(hold));
    jog <= 1'b1;
    cyc(3);
    check("jog running", 16'h0, 16'(jog_o));
    check("second running", 16'h0, 16'(sec_o));
    jog <= 1'b0;
    cyc(ACCEL_CYC);
    start <= 1'b0;
    speed <= 16'h0100;
    wait_for("request off", 0, 1'b0, 50);
    wait_for("output off", 2, 1'b0, 800);
    check("stop wait", 16'h1, 16'(n >= cyc_of(RST_STOP_WAIT)));
    cyc(4);
  endtask

  // A trip no earlier than lo cycles, held until drive reset.
  task automatic trip(input int bitno, input int lo);
    wait_for("trip", 3, 1'b1, 2200);
    check("trip time", 16'h1, 16'(n >= lo));
    check("fault code", 16'h1, 16'(fcode[bitno]));
    check("trip request", 16'h0, 16'(rel_out));
    {start, rev} <= 2'b00;
    cyc(30);
    check("trip output", 16'h0, 16'(out_on));
    check("latched", 16'h1, 16'(fault));
    drv_rst <= 1'b1;
    wait_for("trip clear", 3, 1'b0, 20);
    drv_rst <= 1'b0;
    cyc(4);
  endtask

  // Main sequence: registers, pass-through, both sequence modes and four trips.
  initial
  begin
    {rst_n, wr_stb, rd_stb, start, rev, jog, drv_rst, stuck, drop} = '0;
    addr = 8'h00;
    wr_data = 16'h0000;
    speed = 16'h0000;
    cur = 16'h0000;
    opm = OPM_EXTERNAL;
    cyc(6);
    rst_n <= 1'b1;
    cyc(1);
    for (int i = 0; i < 8; i++)
    begin
      rd(8'(i), d);
      check("reset value", rst_tab[i], d);
    end
    wr(ADDR_RELEASE_FREQ, 16'h02BD);
    wr(ADDR_ENGAGE_FREQ, 16'h0BB9);
    wr(ADDR_RELEASE_CURRENT, 16'h00C9);
    rd(ADDR_STATUS, d);
    check("refused", 16'h1, 16'(d[STAT_REJECT_BIT]));
    rd(ADDR_ENGAGE_FREQ, d);
    check("engage freq", RST_ENGAGE_FREQ, d);
    wr(ADDR_RELEASE_FREQ, RST_ENGAGE_FREQ);
    rd(ADDR_RELEASE_FREQ, d);
    check("release freq", RST_ENGAGE_FREQ, d);
    rd(8'h20, d);
    check("unmapped", 16'h0000, d);
    wr(ADDR_CONTROL, {IN_CODE_RELEASE_DONE, OUT_CODE_NEG});
    cyc(1);
    check("negative request", 16'h1, 16'(rel_out));
    wr(ADDR_CONTROL, RST_CONTROL);
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_ACCEL_MODE, (i == 0) ? MODE_NORMAL : MODE_BRAKE_TIMED);
      opm <= (i == 0) ? OPM_EXTERNAL : OPM_PANEL;
      start <= 1'b1;
      cyc(4);
      check("pass accel", 16'h1, 16'(accel));
      check("pass request", 16'h0, 16'(rel_out));
      start <= 1'b0;
      cyc(4);
    end
    opm <= OPM_NETWORK;
    jog <= 1'b1;
    cyc(4);
    check("jog stopped", 16'h1, 16'(jog_o));
    check("second stopped", 16'h1, 16'(sec_o));
    start <= 1'b1;
    cyc(4);
    check("suspended accel", 16'h1, 16'(accel));
    start <= 1'b0;
    jog <= 1'b0;
    cyc(4);
    run_seq(MODE_BRAKE_TIMED);
    run_seq(MODE_BRAKE_FB);
    speed <= 16'h0400;
    start <= 1'b1;
    wait_for("accel again", 1, 1'b1, 1200);
    drop <= 1'b1;
    trip(FLT_FB_LOST, 0);
    drop <= 1'b0;
    start <= 1'b1;
    wait_for("accel again", 1, 1'b1, 1200);
    stuck <= 1'b1;
    start <= 1'b0;
    speed <= 16'h0100;
    wait_for("request off", 0, 1'b0, 50);
    trip(FLT_NO_ENGAGE, 1990);
    stuck <= 1'b0;
    cyc(40);
    stuck <= 1'b1;
    speed <= 16'h0400;
    start <= 1'b1;
    wait_for("request on", 0, 1'b1, 400);
    trip(FLT_NO_FB, 1990);
    stuck <= 1'b0;
    cur <= 16'h0000;
    rev <= 1'b1;
    trip(FLT_NO_REQ, 1990);
    test_done();
  end
endmodule
